// ---- tb/tff_timer_sva.sv ----
// Timer block checker on its ports.
`timescale 1ns/1ps
module tff_timer_sva #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic external_count_pin_i,
	input wire logic capture0_event_i,
	input wire logic capture1_event_i,
	input wire logic timer_output_flipflop_o,
	input wire logic irq_o
);
	logic [3:0] tg_q;
	logic [2:0] en_q;
	logic ff;
	logic wr;
	logic fw;
	assign ff = timer_output_flipflop_o;
	assign wr = wb_ack_o && wb_we_i;
	assign fw = wr && wb_adr_i == tff_pkg::OFS_FFCTL;
	// Shadows of the toggle enables and interrupt enables follow bus writes.
	always_ff @(posedge clk_i)
	begin
		tg_q <= rst_i ? 4'h0 : fw ? wb_dat_i[5:2] : tg_q;
		en_q <= rst_i ? 3'h0 : wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == tff_pkg::OFS_IRQ_EN ? wb_dat_i[2:0] : en_q;
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_one: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_cap1_tog: assert property (capture1_event_i && tg_q[3] && !wb_cyc_i |=> $changed(ff)) else $error("c1");
	a_cap0_tog: assert property (capture0_event_i && tg_q[2] && !wb_cyc_i |=> $changed(ff)) else $error("c0");
	a_cap_off: assert property (capture1_event_i && tg_q == 4'h0 && !wb_cyc_i |=> $stable(ff)) else $error("c");
	a_cmd_inv: assert property (fw && wb_dat_i[1:0] == 2'h0 |-> $changed(ff)) else $error("inv");
	a_cmd_set: assert property (fw && wb_dat_i[1:0] == 2'h1 |-> ff) else $error("set");
	a_cmd_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == tff_pkg::OFS_FFCTL
		|-> (wb_dat_o[7:6] & wb_dat_o[1:0]) == 2'h3) else $error("rd");
	a_irq_mask: assert property (irq_o |-> en_q != 3'h0 || $past(en_q) != 3'h0) else $error("irq");
endmodule
bind tff_timer tff_timer_sva #(.ADDR_W(ADDR_W)) u_sva (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.external_count_pin_i(external_count_pin_i),
	.capture0_event_i(capture0_event_i),
	.capture1_event_i(capture1_event_i),
	.timer_output_flipflop_o(timer_output_flipflop_o),
	.irq_o(irq_o)
);

// ---- tb/tff_timer_tb.sv ----
// Self-checking testbench of the timer block.
`timescale 1ns/1ps
module tff_timer_tb;
	logic clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, wb_ack_o, irq_o;
	logic capture0_event_i = '0, capture1_event_i = '0, external_count_pin_i = '0, timer_output_flipflop_o;
	logic [7:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = '0, wb_dat_o, r, c0;
	logic [15:0] regs [4] = '{16'h0020, 16'h04c3, 16'h0800, 16'h2000};
	logic [2:0] rows [7] = '{3'h3, 3'h0, 3'h1, 3'h7, 3'h4, 3'h6, 3'h1};
	logic [5:0] srcs [4] = '{6'h8, 6'h21, 6'h8, 6'h2};
	int failures = 0, n_tests = 0;
	tff_timer dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.external_count_pin_i(external_count_pin_i),
		.capture0_event_i(capture0_event_i),
		.capture1_event_i(capture1_event_i),
		.timer_output_flipflop_o(timer_output_flipflop_o),
		.irq_o(irq_o)
	);
	initial forever #5 clk_i = ~clk_i;
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		for (int k = 0; k < 9 && wb_ack_o !== 1'b1; k++)
			@(posedge clk_i);
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		chk(wb_ack_o, 1'b1);
		if (wb_ack_o !== 1'b1)
			report_and_stop();
	endtask
	task pulse(input logic [1:0] p, input logic e);
		@(posedge clk_i);
		{capture1_event_i, capture0_event_i} <= p;
		@(posedge clk_i);
		{capture1_event_i, capture0_event_i} <= 2'h0;
		@(posedge clk_i);
		chk(timer_output_flipflop_o, e);
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= '0;
		foreach (regs[k])
		begin
			wb(0, regs[k][15:8], '0);
			chk(r, 32'(regs[k][7:0]));
		end
		$display("reset done");
		foreach (rows[k])
		begin
			wb(1, 8'h04, 32'(rows[k][2:1]));
			chk(timer_output_flipflop_o, rows[k][0]);
			wb(0, 8'h04, '0);
			chk(r, 32'hc3);
		end
		wb(1, 8'h04, 32'h33);
		pulse(2'h1, 1'b0);
		pulse(2'h2, 1'b1);
		pulse(2'h3, 1'b0);
		wb(1, 8'h04, 32'h3);
		pulse(2'h3, 1'b0);
		$display("flip-flop done");
		wb(1, 8'h14, 32'h3);
		wb(1, 8'h18, 32'h5);
		wb(1, 8'h00, 32'h25);
		wb(1, 8'h04, 32'hf);
		wb(1, 8'h10, 32'h1);
		repeat (60) @(posedge clk_i);
		chk(irq_o, 1'b0);
		wb(0, 8'h1c, '0);
		chk(r < 6, 1'b1);
		wb(1, 8'h10, '0);
		wb(1, 8'h0c, 32'h7);
		@(posedge clk_i);
		chk(irq_o, 1'b1);
		wb(0, 8'h08, '0);
		chk(r, 32'h3);
		wb(0, 8'h08, '0);
		chk(r, '0);
		chk(irq_o, 1'b0);
		$display("compare done");
		wb(1, 8'h10, 32'h1);
		foreach (srcs[k])
		begin
			wb(1, 8'h00, 32'h20 | 32'(k));
			wb(0, 8'h1c, '0);
			c0 = r;
			repeat (16)
			begin
				repeat (4) @(posedge clk_i);
				external_count_pin_i <= ~external_count_pin_i;
			end
			wb(0, 8'h1c, '0);
			chk(16'(r - c0 - 32'(srcs[k])) <= 16'h1, 1'b1);
		end
		$display("sources done");
		wb(1, 8'h10, '0);
		wb(1, 8'h04, 32'h1);
		chk(timer_output_flipflop_o, 1'b1);
		rst_i <= '1;
		repeat (2) @(posedge clk_i);
		rst_i <= '0;
		chk(timer_output_flipflop_o, 1'b0);
		wb(0, 8'h04, '0);
		chk(r, 32'hc3);
		wb(0, 8'h00, '0);
		chk(r, 32'h20);
		$display("mid-run reset done");
		report_and_stop();
	end
endmodule

// ---- verilog/tff_pkg.sv ----
// Package with register map, field positions, reset values and prescaler constants of the timer flip-flop block.
package tff_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_FFCTL = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
	localparam logic [7:0] OFS_RUN = 8'h10;
	localparam logic [7:0] OFS_CMP0 = 8'h14;
	localparam logic [7:0] OFS_CMP1 = 8'h18;
	localparam logic [7:0] OFS_COUNT = 8'h1c;

	// Mode register fields.
	localparam int MODE_SRC_LSB = 0;
	localparam int MODE_CLR_BIT = 2;
	localparam int MODE_W = 7;
	localparam logic [6:0] MODE_RST = 7'h20;

	// Count source codes.
	localparam logic [1:0] SRC_PIN = 2'h0;
	localparam logic [1:0] SRC_TAP1 = 2'h1;
	localparam logic [1:0] SRC_TAP4 = 2'h2;
	localparam logic [1:0] SRC_TAP16 = 2'h3;

	// Flip-flop control fields.
	localparam int FF_CMD_LSB = 0;
	localparam int FF_TOG_CMP0 = 2;
	localparam int FF_TOG_CMP1 = 3;
	localparam int FF_TOG_CAP0 = 4;
	localparam int FF_TOG_CAP1 = 5;
	localparam logic [1:0] FF_CMD_INVERT = 2'h0;
	localparam logic [1:0] FF_CMD_SET = 2'h1;
	localparam logic [1:0] FF_CMD_CLEAR = 2'h2;
	localparam logic [1:0] FF_CMD_NONE = 2'h3;
	localparam logic [3:0] FF_TOG_RST = 4'h0;
	localparam logic [1:0] FF_HIGH_BITS = 2'h3;

	// Event flag positions.
	localparam int FLAG_CMP0 = 0;
	localparam int FLAG_CMP1 = 1;
	localparam int FLAG_OVF = 2;
	localparam int FLAG_W = 3;

	// Prescaler: the first tap pulses every 2 clocks, then 8 and 32 clocks.
	localparam int PRESC_W = 5;
	localparam logic [4:0] TAP1_MASK = 5'h01;
	localparam logic [4:0] TAP4_MASK = 5'h07;
	localparam logic [4:0] TAP16_MASK = 5'h1f;

	localparam int CNT_W = 16;
endpackage

// ---- verilog/tff_timer.sv ----
// Timer channel with mode register, output flip-flop control and read-clear event flags on classic Wishbone.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Functional notes
// (RQ1) With clear enable set, a compare-1 match resets the counter; otherwise never.
// (RQ2) Source code 00 pin, 01 first tap, 10 divide-by-4, 11 divide-by-16.
// (RQ3) Capture-1 latch toggles the flip-flop when its enable bit 5 is set.
// (RQ4) Capture-0 latch toggles the flip-flop when its enable bit 4 is set.
// (RQ5) Compare-1 match toggles the flip-flop when enable bit 3 is set.
// (RQ6) Compare-0 match toggles the flip-flop when enable bit 2 is set.
// (RQ7) Writing command 00 inverts the flip-flop at once.
// (RQ8) Command 01 sets the flip-flop, command 10 clears it.
// (RQ9) Command 11 does nothing; the command field always reads 11.
// (RQ10) Software changes flip-flop control only while the channel is stopped.
// (RQ11) Software writes mode bit 6 as 0, bit 5 as 1, bits 4-3 as 00.
// (RQ12) Sixteen-bit counter advances once per selected source edge while running.
// (RQ13) Overflow sets the overflow flag; compare matches set their match flags.
// (RQ14) Reading the flag register clears the flags; nothing else clears them.
// (RQ15) Flags set regardless of mask; only enabled flags raise the interrupt.
// (RQ16) Each compare register holds sixteen bits compared continuously with the counter; the code compares only on a count edge while running.
module tff_timer #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic external_count_pin_i,
	input wire logic capture0_event_i,
	input wire logic capture1_event_i,
	output logic timer_output_flipflop_o,
	output logic irq_o
);

	// The address must reach the highest register offset.
	if (ADDR_W < 8)
	begin : g_addr_check
		$error("ADDR_W must be at least 8.");
	end

	// The toggle enables must sit in bits 5 to 2, above the command field.
	if (tff_pkg::FF_TOG_CAP1 - tff_pkg::FF_TOG_CMP0 != 3 || tff_pkg::FF_TOG_CMP0 != 2)
	begin : g_toggle_check
		$error("Toggle enable fields must be bits 5 to 2.");
	end

	// The prescaler must be wide enough for the divide-by-16 tap.
	if (tff_pkg::PRESC_W < 5)
	begin : g_presc_check
		$error("Prescaler must reach the divide-by-16 tap.");
	end

	// The flag register holds exactly the two match flags and the overflow flag.
	if (tff_pkg::FLAG_W != 3)
	begin : g_flag_check
		$error("Three event flags are expected.");
	end

	// The mode register holds source and clear enable within byte lane 0.
	if (tff_pkg::MODE_W < 3 || tff_pkg::MODE_W > 8)
	begin : g_mode_check
		$error("Mode register must fit in one byte.");
	end

	// The counter and both compare registers are sixteen bits wide.
	if (tff_pkg::CNT_W != 16)
	begin : g_count_check
		$error("Counter width must be 16.");
	end

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [tff_pkg::MODE_W-1:0] mode;
		logic [3:0] toggle_en;
		logic flipflop;
		logic [tff_pkg::FLAG_W-1:0] flags;
		logic [tff_pkg::FLAG_W-1:0] irq_en;
		logic irq;
		logic run;
		logic [tff_pkg::CNT_W-1:0] cmp0;
		logic [tff_pkg::CNT_W-1:0] cmp1;
		logic [tff_pkg::CNT_W-1:0] count;
		logic [tff_pkg::PRESC_W-1:0] presc;
		logic [2:0] pin_sync;
		logic pin_level;
	} tff_state_s;

	tff_state_s s_q;
	tff_state_s s_d;

	logic req;
	logic wr;
	logic rd;
	logic [7:0] adr;
	logic [15:0] wmask;
	logic tick;
	logic pin_rise;
	logic match0;
	logic match1;
	logic ovf;
	logic toggle;
	logic [1:0] src;
	logic [1:0] cmd;
	logic [tff_pkg::FLAG_W-1:0] ev;
	logic [3:0] tog_src;
	logic [tff_pkg::FLAG_W-1:0] irq_pend;

	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_comb
	begin
		s_d = s_q;
		req = wb_cyc_i && wb_stb_i && !s_q.ack;
		wr = req && wb_we_i;
		rd = req && !wb_we_i;
		adr = {wb_adr_i[7:2], 2'h0};
		src = s_q.mode[tff_pkg::MODE_SRC_LSB +: 2];
		cmd = wb_dat_i[tff_pkg::FF_CMD_LSB +: 2];

		// External pin passes three flops; a rising change counts once the last two agree.
		s_d.pin_sync = {s_q.pin_sync[1:0], external_count_pin_i};
		pin_rise = 1'b0;
		if (s_q.pin_sync[2] == s_q.pin_sync[1])
		begin
			s_d.pin_level = s_q.pin_sync[2];
			pin_rise = s_q.pin_sync[2] && !s_q.pin_level;
		end

		// Free running prescaler supplies the three internal taps.
		s_d.presc = s_q.presc + 1'b1;
		case (src) // RQ2
			tff_pkg::SRC_PIN:
			begin
				tick = pin_rise;
			end
			tff_pkg::SRC_TAP1:
			begin
				tick = (s_q.presc & tff_pkg::TAP1_MASK) == tff_pkg::TAP1_MASK;
			end
			tff_pkg::SRC_TAP4:
			begin
				tick = (s_q.presc & tff_pkg::TAP4_MASK) == tff_pkg::TAP4_MASK;
			end
			tff_pkg::SRC_TAP16:
			begin
				tick = (s_q.presc & tff_pkg::TAP16_MASK) == tff_pkg::TAP16_MASK;
			end
			default:
			begin
				tick = 1'b0;
			end
		endcase
		tick = tick && s_q.run;

		// Matches and overflow are events of the count edge.
		match0 = tick && (s_q.count == s_q.cmp0); // RQ16
		match1 = tick && (s_q.count == s_q.cmp1); // RQ16
		ovf = tick && (s_q.count == {tff_pkg::CNT_W{1'b1}});
		if (match1 && s_q.mode[tff_pkg::MODE_CLR_BIT]) // RQ1
		begin
			s_d.count = '0;
			ovf = 1'b0;
		end
		else if (tick)
		begin
			s_d.count = s_q.count + 1'b1; // RQ12
		end

		// Hardware toggle sources; several in one cycle toggle once.
		tog_src = '0;
		tog_src[tff_pkg::FF_TOG_CMP0 - 2] = match0; // RQ6
		tog_src[tff_pkg::FF_TOG_CMP1 - 2] = match1; // RQ5
		tog_src[tff_pkg::FF_TOG_CAP0 - 2] = capture0_event_i; // RQ4
		tog_src[tff_pkg::FF_TOG_CAP1 - 2] = capture1_event_i; // RQ3
		toggle = |(tog_src & s_q.toggle_en);
		if (toggle)
		begin
			s_d.flipflop = !s_q.flipflop;
		end

		// Read data, captured before any read side effect.
		s_d.ack = req;
		s_d.rdata = '0;
		if (rd)
		begin
			case (adr)
				tff_pkg::OFS_MODE:
				begin
					s_d.rdata[tff_pkg::MODE_W-1:0] = s_q.mode;
				end
				tff_pkg::OFS_FFCTL:
				begin
					s_d.rdata[7:0] = {tff_pkg::FF_HIGH_BITS, s_q.toggle_en, tff_pkg::FF_CMD_NONE}; // RQ9
				end
				tff_pkg::OFS_FLAGS:
				begin
					s_d.rdata[tff_pkg::FLAG_W-1:0] = s_q.flags;
				end
				tff_pkg::OFS_IRQ_EN:
				begin
					s_d.rdata[tff_pkg::FLAG_W-1:0] = s_q.irq_en;
				end
				tff_pkg::OFS_RUN:
				begin
					s_d.rdata[0] = s_q.run;
				end
				tff_pkg::OFS_CMP0:
				begin
					s_d.rdata[tff_pkg::CNT_W-1:0] = s_q.cmp0;
				end
				tff_pkg::OFS_CMP1:
				begin
					s_d.rdata[tff_pkg::CNT_W-1:0] = s_q.cmp1;
				end
				tff_pkg::OFS_COUNT:
				begin
					s_d.rdata[tff_pkg::CNT_W-1:0] = s_q.count;
				end
				default:
				begin
					s_d.rdata = '0;
				end
			endcase
		end

		// Register writes honour byte lanes.
		if (wr)
		begin
			case (adr)
				tff_pkg::OFS_MODE:
				begin
					if (wb_sel_i[0])
					begin
						s_d.mode = wb_dat_i[tff_pkg::MODE_W-1:0];
					end
				end

				tff_pkg::OFS_FFCTL:
				begin
					if (wb_sel_i[0])
					begin
						s_d.toggle_en = wb_dat_i[tff_pkg::FF_TOG_CAP1:tff_pkg::FF_TOG_CMP0];
						case (cmd)
							tff_pkg::FF_CMD_INVERT:
							begin
								s_d.flipflop = !s_q.flipflop; // RQ7
							end
							tff_pkg::FF_CMD_SET:
							begin
								s_d.flipflop = 1'b1; // RQ8
							end
							tff_pkg::FF_CMD_CLEAR:
							begin
								s_d.flipflop = 1'b0; // RQ8
							end
							tff_pkg::FF_CMD_NONE:
							begin
								s_d.flipflop = s_d.flipflop; // RQ9
							end
							default:
							begin
								s_d.flipflop = s_d.flipflop;
							end
						endcase
					end
				end

				tff_pkg::OFS_IRQ_EN:
				begin
					if (wb_sel_i[0])
					begin
						s_d.irq_en = wb_dat_i[tff_pkg::FLAG_W-1:0];
					end
				end

				tff_pkg::OFS_RUN:
				begin
					if (wb_sel_i[0])
					begin
						s_d.run = wb_dat_i[0];
					end
				end

				tff_pkg::OFS_CMP0:
				begin
					s_d.cmp0 = (s_q.cmp0 & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				end
				tff_pkg::OFS_CMP1:
				begin
					s_d.cmp1 = (s_q.cmp1 & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				end

				default:
				begin
					s_d.run = s_d.run;
				end
			endcase
		end

		// Sticky flags: a read clears them, a new event in the same cycle wins.
		ev = '0;
		ev[tff_pkg::FLAG_CMP0] = match0; // RQ13
		ev[tff_pkg::FLAG_CMP1] = match1; // RQ13
		ev[tff_pkg::FLAG_OVF] = ovf; // RQ13
		for (int i = 0; i < tff_pkg::FLAG_W; i++)
		begin
			if (ev[i]) // RQ15
			begin
				s_d.flags[i] = 1'b1;
			end
			else if (rd && adr == tff_pkg::OFS_FLAGS) // RQ14
			begin
				s_d.flags[i] = 1'b0;
			end
		end
		// Level interrupt from the enabled flags only.
		irq_pend = s_d.flags & s_d.irq_en;
		s_d.irq = |irq_pend; // RQ15
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q <= '0;
			s_q.mode <= tff_pkg::MODE_RST;
			s_q.toggle_en <= tff_pkg::FF_TOG_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Every output comes straight from the state flops.
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdata;
	assign timer_output_flipflop_o = s_q.flipflop;
	assign irq_o = s_q.irq;

endmodule
